/* File: hw/rtcyd_top.sv */
`timescale 1ns/1ps
`include "rtcyd_cfg.svh"

// Contract
// - Current year is a read-only 14-bit BCD field, reset to 2000.
// - Year match is a read-write 14-bit BCD field, reset to 2000.
// - Year load is read-write 14-bit BCD, reset zero, loaded into the year.
// - Second tick comes every divider factor plus one slow clock cycles.
// - Divider zero: timer gets every slow cycle, calendar tick stops.
// - Divider and trim writes ignored while calendar enabled; reads return stored.
// - Trim count of slow pulses deleted in each 1023-cycle period.
// - Trim zero deletes nothing; each code step deletes one more pulse.
// - Calendar enable locks the whole control register until reset.
// - Mask bit 0 enables calendar interrupt; resets to zero.
// - Mask bit 1 enables timer interrupt; resets to zero.
// - Raw status bit 0 shows calendar interrupt before masking; resets zero.
// - Raw status bit 1 shows timer interrupt before masking; resets zero.
// - Masked status is raw state gated by the matching enable bit.
// - Writing one to a clear bit clears that interrupt; zero does nothing.
// - Timer raw interrupt rises each time the timer count reaches zero.
module rtcyd_top (
  input  wire logic                      clock_i,
  input  wire logic                      sys_rst_i,
  input  wire rtcyd_pkg::rtcyd_apb_req_t apb_req_i,
  output logic [31:0]                    prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  input  wire logic                      slow_clock_i,
  input  wire logic                      date_match_i,
  input  wire logic                      year_rollover_i,
  input  wire logic                      timer_zero_i,
  output logic                           calendar_tick_o,
  output logic                           timer_tick_o,
  output logic                           calendar_enable_o,
  output logic [13:0]                    year_value_o,
  output logic                           irq_o
);
  import rtcyd_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // BCD year increment, 3999 wraps to 0000
  function automatic logic [13:0] bcd_year_inc(input logic [13:0] y);
    logic [3:0] d0;
    logic [3:0] d1;
    logic [3:0] d2;
    logic [1:0] d3;
    d0 = y[3:0];
    d1 = y[7:4];
    d2 = y[11:8];
    d3 = y[13:12];
    if (d0 != 4'h9) begin
      d0 = d0 + 4'h1;
    end else begin
      d0 = 4'h0;
      if (d1 != 4'h9) begin
        d1 = d1 + 4'h1;
      end else begin
        d1 = 4'h0;
        if (d2 != 4'h9) begin
          d2 = d2 + 4'h1;
        end else begin
          d2 = 4'h0;
          d3 = d3 + 2'h1;
        end
      end
    end
    return {d3, d2, d1, d0};
  endfunction

  function automatic logic hits(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [13:0] year_value_reg;
  logic [13:0] year_match_value_reg;
  logic [13:0] year_load_value_reg;
  rtcyd_ctrl_t ctrl_reg;
  logic [1:0]  irq_enable_reg;
  logic [1:0]  irq_raw_reg;
  logic [1:0]  irq_raw_next;
  logic [31:0] prdata_reg;
  logic        irq_reg;

  // ----------------------------------------------------------------
  // APB slave: zero wait states, read data captured in setup phase
  // ----------------------------------------------------------------
  logic        apb_setup;
  logic        apb_access;
  logic        apb_wr;
  logic        apb_rd;
  logic        addr_mapped;
  logic [11:0] addr;
  logic [31:0] read_mux;

  assign addr       = apb_req_i.paddr;
  assign apb_setup  = apb_req_i.psel & ~apb_req_i.penable;
  assign apb_access = apb_req_i.psel & apb_req_i.penable;
  assign apb_wr     = apb_access & apb_req_i.pwrite & addr_mapped;
  assign apb_rd     = apb_access & ~apb_req_i.pwrite & addr_mapped;

  assign addr_mapped = hits(addr, `RTCYD_OFS_YEAR_CURRENT) | hits(addr, `RTCYD_OFS_YEAR_MATCH)
                     | hits(addr, `RTCYD_OFS_YEAR_LOAD) | hits(addr, `RTCYD_OFS_DIV_TRIM_CTRL)
                     | hits(addr, `RTCYD_OFS_IRQ_MASK) | hits(addr, `RTCYD_OFS_IRQ_RAW)
                     | hits(addr, `RTCYD_OFS_IRQ_MASKED) | hits(addr, `RTCYD_OFS_IRQ_CLEAR);

  assign pready_o  = apb_access;
  assign pslverr_o = apb_access & ~addr_mapped;

  always_comb begin
    read_mux = 32'h0000_0000;
    case (addr)
      `RTCYD_OFS_YEAR_CURRENT:  read_mux[13:0] = year_value_reg;
      `RTCYD_OFS_YEAR_MATCH:    read_mux[13:0] = year_match_value_reg;
      `RTCYD_OFS_YEAR_LOAD:     read_mux[13:0] = year_load_value_reg;
      `RTCYD_OFS_DIV_TRIM_CTRL: begin
        read_mux[`RTCYD_DIV_MSB:`RTCYD_DIV_LSB]   = ctrl_reg.divider_factor;
        read_mux[`RTCYD_TRIM_MSB:`RTCYD_TRIM_LSB] = ctrl_reg.trim_delete_count;
        read_mux[`RTCYD_CAL_EN_BIT]               = ctrl_reg.calendar_enable;
      end
      `RTCYD_OFS_IRQ_MASK:      read_mux[1:0] = irq_enable_reg;
      `RTCYD_OFS_IRQ_RAW:       read_mux[1:0] = irq_raw_reg;
      `RTCYD_OFS_IRQ_MASKED:    read_mux[1:0] = irq_raw_reg & irq_enable_reg;
      default:                  read_mux = 32'h0000_0000;
    endcase
  end

  // Captured at setup so the data bus is flop-driven during access
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      prdata_reg <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_reg <= read_mux;
    end
  end
  assign prdata_o = prdata_reg;

  // ----------------------------------------------------------------
  // Year registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      year_match_value_reg <= `RTCYD_YEAR_MATCH_RST;
      year_load_value_reg  <= `RTCYD_YEAR_LOAD_RST;
    end else if (apb_wr) begin
      if (hits(addr, `RTCYD_OFS_YEAR_MATCH)) begin
        year_match_value_reg <= apb_req_i.pwdata[13:0];
      end
      if (hits(addr, `RTCYD_OFS_YEAR_LOAD)) begin
        year_load_value_reg <= apb_req_i.pwdata[13:0];
      end
    end
  end

  // A load write wins over a rollover in the same cycle
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      year_value_reg <= `RTCYD_YEAR_RST;
    end else if (apb_wr && hits(addr, `RTCYD_OFS_YEAR_LOAD)) begin
      year_value_reg <= apb_req_i.pwdata[13:0];
    end else if (year_rollover_i && ctrl_reg.calendar_enable) begin
      year_value_reg <= bcd_year_inc(year_value_reg);
    end
  end
  assign year_value_o = year_value_reg;

  // ----------------------------------------------------------------
  // Control register, locked once the calendar is enabled
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ctrl_reg.divider_factor    <= `RTCYD_DIV_RST;
      ctrl_reg.trim_delete_count <= `RTCYD_TRIM_RST;
      ctrl_reg.calendar_enable   <= 1'b0;
    end else if (apb_wr && hits(addr, `RTCYD_OFS_DIV_TRIM_CTRL)
                 && !ctrl_reg.calendar_enable) begin
      ctrl_reg.divider_factor    <= apb_req_i.pwdata[`RTCYD_DIV_MSB:`RTCYD_DIV_LSB];
      ctrl_reg.trim_delete_count <= apb_req_i.pwdata[`RTCYD_TRIM_MSB:`RTCYD_TRIM_LSB];
      ctrl_reg.calendar_enable   <= apb_req_i.pwdata[`RTCYD_CAL_EN_BIT];
    end
  end
  assign calendar_enable_o = ctrl_reg.calendar_enable;

  // ----------------------------------------------------------------
  // Slow clock sampling and second tick derivation
  // ----------------------------------------------------------------
  logic        slow_meta_reg;
  logic        slow_sync_reg;
  logic        slow_prev_reg;
  logic        slow_tick;
  logic [9:0]  trim_cnt_reg;
  logic        live_tick;
  logic [14:0] div_cnt_reg;
  logic        div_wrap;
  logic        cal_tick_reg;
  logic        tmr_tick_reg;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      slow_meta_reg <= 1'b0;
      slow_sync_reg <= 1'b0;
      slow_prev_reg <= 1'b0;
    end else begin
      slow_meta_reg <= slow_clock_i;
      slow_sync_reg <= slow_meta_reg;
      slow_prev_reg <= slow_sync_reg;
    end
  end
  assign slow_tick = slow_sync_reg & ~slow_prev_reg;

  // Trim period spans 1023 slow cycles; the first N of each are deleted
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      trim_cnt_reg <= 10'h000;
    end else if (slow_tick) begin
      trim_cnt_reg <= (trim_cnt_reg == `RTCYD_TRIM_PERIOD - 10'h001) ? 10'h000
                    : trim_cnt_reg + 10'h001;
    end
  end
  assign live_tick = slow_tick & (trim_cnt_reg >= ctrl_reg.trim_delete_count);

  // Counter compares with >= so a lowered factor never overruns
  assign div_wrap = live_tick & (div_cnt_reg >= ctrl_reg.divider_factor);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      div_cnt_reg <= 15'h0000;
    end else if (live_tick) begin
      div_cnt_reg <= div_wrap ? 15'h0000 : div_cnt_reg + 15'h0001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cal_tick_reg <= 1'b0;
      tmr_tick_reg <= 1'b0;
    end else if (ctrl_reg.divider_factor == 15'h0000) begin
      cal_tick_reg <= 1'b0;
      tmr_tick_reg <= slow_tick;
    end else begin
      cal_tick_reg <= div_wrap;
      tmr_tick_reg <= div_wrap;
    end
  end
  assign calendar_tick_o = cal_tick_reg;
  assign timer_tick_o    = tmr_tick_reg;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [1:0] irq_set;
  logic [1:0] irq_clr;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      irq_enable_reg <= 2'h0;
    end else if (apb_wr && hits(addr, `RTCYD_OFS_IRQ_MASK)) begin
      irq_enable_reg <= apb_req_i.pwdata[1:0];
    end
  end

  assign irq_set[`RTCYD_IRQ_CAL_BIT] = date_match_i & ctrl_reg.calendar_enable
                                     & (year_value_reg == year_match_value_reg);
  assign irq_set[`RTCYD_IRQ_TMR_BIT] = timer_zero_i;

  // Clear by write-one or by reading the raw status
  always_comb begin
    irq_clr = 2'h0;
    if (apb_wr && hits(addr, `RTCYD_OFS_IRQ_CLEAR)) begin
      irq_clr = apb_req_i.pwdata[1:0];
    end
    // Only bits already captured for software are cleared, so an event
    // landing between setup and access survives the read
    if (apb_rd && hits(addr, `RTCYD_OFS_IRQ_RAW)) begin
      irq_clr = prdata_reg[1:0];
    end
  end

  // A set in the clearing cycle wins so no event is lost
  assign irq_raw_next = (irq_raw_reg & ~irq_clr) | irq_set;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      irq_raw_reg <= 2'h0;
      irq_reg     <= 1'b0;
    end else begin
      irq_raw_reg <= irq_raw_next;
      irq_reg     <= |(irq_raw_next & irq_enable_reg);
    end
  end
  assign irq_o = irq_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  sequence ctrl_write_s;
    apb_wr && hits(addr, `RTCYD_OFS_DIV_TRIM_CTRL);
  endsequence

  sequence load_write_s;
    apb_wr && hits(addr, `RTCYD_OFS_YEAR_LOAD);
  endsequence

  sequence mask_write_s;
    apb_wr && hits(addr, `RTCYD_OFS_IRQ_MASK);
  endsequence

  sequence raw_read_s;
    apb_rd && hits(addr, `RTCYD_OFS_IRQ_RAW);
  endsequence

  // Year registers
  year_load_a: assert property (
    load_write_s |=> year_value_reg == $past(apb_req_i.pwdata[13:0]))
    else $error("year not loaded");
  year_roll_a: assert property (
    year_rollover_i && ctrl_reg.calendar_enable
    && !(apb_wr && hits(addr, `RTCYD_OFS_YEAR_LOAD))
    |=> year_value_reg == bcd_year_inc($past(year_value_reg)))
    else $error("year did not advance");
  year_hold_a: assert property (
    !(apb_wr && hits(addr, `RTCYD_OFS_YEAR_LOAD))
    && !(year_rollover_i && ctrl_reg.calendar_enable) |=> $stable(year_value_reg))
    else $error("year changed without load or rollover");
  match_hold_a: assert property (
    !(apb_wr && hits(addr, `RTCYD_OFS_YEAR_MATCH)) |=> $stable(year_match_value_reg))
    else $error("year match changed without write");

  // Control register and tick derivation
  ctrl_lock_a: assert property (
    ctrl_reg.calendar_enable |=> ctrl_reg == $past(ctrl_reg))
    else $error("locked control changed");
  ctrl_write_a: assert property (
    ctrl_write_s and !ctrl_reg.calendar_enable
    |=> ctrl_reg.divider_factor == $past(apb_req_i.pwdata[14:0]))
    else $error("divider write lost");
  cal_stop_a: assert property (
    ctrl_reg.divider_factor == 15'h0000 |=> !cal_tick_reg)
    else $error("calendar tick with zero divider");
  tmr_fast_a: assert property (
    ctrl_reg.divider_factor == 15'h0000 && slow_tick |=> tmr_tick_reg)
    else $error("timer tick missing");
  trim_drop_a: assert property (
    slow_tick && trim_cnt_reg < ctrl_reg.trim_delete_count |=> $stable(div_cnt_reg))
    else $error("trimmed pulse counted");
  div_tick_a: assert property (
    live_tick && ctrl_reg.divider_factor != 15'h0000
    && div_cnt_reg == ctrl_reg.divider_factor |=> cal_tick_reg ##1 !cal_tick_reg)
    else $error("second tick not one pulse");

  // Interrupt status, mask and clear
  timer_set_a: assert property (
    timer_zero_i |=> irq_raw_reg[`RTCYD_IRQ_TMR_BIT])
    else $error("timer raw not set");
  cal_set_a: assert property (
    irq_set[`RTCYD_IRQ_CAL_BIT] |=> irq_raw_reg[`RTCYD_IRQ_CAL_BIT])
    else $error("calendar raw not set");
  clr_work_a: assert property (
    apb_wr && hits(addr, `RTCYD_OFS_IRQ_CLEAR)
    && apb_req_i.pwdata[0] && !irq_set[0] |=> !irq_raw_reg[0])
    else $error("calendar clear failed");
  raw_clr_a: assert property (
    raw_read_s and (prdata_reg[1] && !irq_set[1]) |=> !irq_raw_reg[1])
    else $error("timer raw not cleared by read");
  mask_write_a: assert property (
    mask_write_s |=> irq_enable_reg == $past(apb_req_i.pwdata[1:0]))
    else $error("mask write lost");
  irq_gate_a: assert property (
    irq_o == |(irq_raw_reg & $past(irq_enable_reg)))
    else $error("interrupt not raw gated by mask");
  irq_mask_a: assert property (
    irq_raw_reg == 2'h0 ##1 irq_raw_reg == 2'h0 |-> !irq_o)
    else $error("interrupt with no raw status");
  cal_hold_a: assert property (
    irq_raw_reg[0] && irq_clr[0] == 1'b0 |=> irq_raw_reg[0])
    else $error("calendar raw dropped");

endmodule

/* File: hw/rtcyd_cfg.svh */
`ifndef RTCYD_CFG_SVH
`define RTCYD_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define RTCYD_OFS_YEAR_CURRENT  12'h00C
`define RTCYD_OFS_YEAR_MATCH    12'h010
`define RTCYD_OFS_YEAR_LOAD     12'h014
`define RTCYD_OFS_DIV_TRIM_CTRL 12'h018
`define RTCYD_OFS_IRQ_MASK      12'h01C
`define RTCYD_OFS_IRQ_RAW       12'h020
`define RTCYD_OFS_IRQ_MASKED    12'h024
`define RTCYD_OFS_IRQ_CLEAR     12'h028

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RTCYD_YEAR_MSB    13
`define RTCYD_DIV_MSB     14
`define RTCYD_DIV_LSB     0
`define RTCYD_TRIM_MSB    25
`define RTCYD_TRIM_LSB    16
`define RTCYD_CAL_EN_BIT  26
`define RTCYD_IRQ_CAL_BIT 0
`define RTCYD_IRQ_TMR_BIT 1

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define RTCYD_YEAR_RST       14'h2000
`define RTCYD_YEAR_MATCH_RST 14'h2000
`define RTCYD_YEAR_LOAD_RST  14'h0000
`define RTCYD_DIV_RST        15'h7FFF
`define RTCYD_TRIM_RST       10'h000
`define RTCYD_TRIM_PERIOD    10'h3FF

`endif

/* File: hw/rtcyd_pkg.sv */
package rtcyd_pkg;

  // APB request as driven by the bus master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rtcyd_apb_req_t;

  // Control register image
  typedef struct packed {
    logic        calendar_enable;
    logic [9:0]  trim_delete_count;
    logic [14:0] divider_factor;
  } rtcyd_ctrl_t;

endpackage

/* File: sim/rtcyd_top_tb_top.sv */
`timescale 1ns/1ps
`include "rtcyd_cfg.svh"

module rtcyd_top_tb_top;
  import rtcyd_pkg::*;

  logic                 clock_i         = 1'b0;
  logic                 sys_rst_i       = 1'b1;
  rtcyd_apb_req_t       apb_req         = '0;
  logic                 slow_clock_i    = 1'b0;
  logic                 date_match_i    = 1'b0;
  logic                 year_rollover_i = 1'b0;
  logic                 timer_zero_i    = 1'b0;
  logic [31:0]          prdata_o;
  logic                 pready_o;
  logic                 pslverr_o;
  logic                 calendar_tick_o;
  logic                 timer_tick_o;
  logic                 calendar_enable_o;
  logic [13:0]          year_value_o;
  logic                 irq_o;
  int                   miscompares     = 0;
  int                   total_checks    = 0;
  int                   slow_div        = 0;
  int                   tmr_cnt         = 0;
  int                   cal_cnt         = 0;
  int                   tmr_n           = 0;
  int                   cal_n           = 0;
  logic [31:0]          rd;
  logic                 err;

  rtcyd_top rtcyd_top_i (
    .clock_i           (clock_i),
    .sys_rst_i         (sys_rst_i),
    .apb_req_i         (apb_req),
    .prdata_o          (prdata_o),
    .pready_o          (pready_o),
    .pslverr_o         (pslverr_o),
    .slow_clock_i      (slow_clock_i),
    .date_match_i      (date_match_i),
    .year_rollover_i   (year_rollover_i),
    .timer_zero_i      (timer_zero_i),
    .calendar_tick_o   (calendar_tick_o),
    .timer_tick_o      (timer_tick_o),
    .calendar_enable_o (calendar_enable_o),
    .year_value_o      (year_value_o),
    .irq_o             (irq_o)
  );

  // ----------------------------------------------------------------
  // Clocks and tick counters
  // ----------------------------------------------------------------
  always #12.5 clock_i = ~clock_i;

  // Slow clock is far slower than the bus clock, so a period of 12 cycles keeps runs short
  always @(posedge clock_i) begin
    slow_div <= (slow_div == 5) ? 0 : slow_div + 1;
    if (slow_div == 5) begin
      slow_clock_i <= ~slow_clock_i;
    end
    if (timer_tick_o === 1'b1) begin
      tmr_cnt <= tmr_cnt + 1;
    end
    if (calendar_tick_o === 1'b1) begin
      cal_cnt <= cal_cnt + 1;
    end
  end

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic finish_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // APB master
  // ----------------------------------------------------------------
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic e);
    @(posedge clock_i);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clock_i);
    apb_req.penable <= 1'b1;
    // No cycle count assumed: only the watchdog ends a hung wait
    do begin
      @(posedge clock_i);
    end while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    apb_req <= '0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb_xfer(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb_xfer(1'b0, a, 32'h0, rd, err);
    chk32(rd, exp);
  endtask

  // One-cycle pulse on an event input: 0 timer zero, 1 date match, 2 rollover
  task automatic pulse(input int k);
    @(posedge clock_i);
    case (k)
      0: timer_zero_i <= 1'b1;
      1: date_match_i <= 1'b1;
      default: year_rollover_i <= 1'b1;
    endcase
    @(posedge clock_i);
    timer_zero_i <= 1'b0;
    date_match_i <= 1'b0;
    year_rollover_i <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask

  // Counts ticks over whole slow periods; ticks lag the pin, so bounds allow one either way
  // Deltas of the free-running counters, so only one process writes them
  task automatic count_ticks(input int edges);
    int t0;
    int c0;
    @(posedge slow_clock_i);
    @(posedge clock_i);
    t0 = tmr_cnt;
    c0 = cal_cnt;
    repeat (edges) @(posedge slow_clock_i);
    @(posedge clock_i);
    tmr_n = tmr_cnt - t0;
    cal_n = cal_cnt - c0;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    chk32({18'h0, year_value_o}, 32'h2000);
    chk32({31'h0, irq_o}, 32'h0);
    rd_chk(`RTCYD_OFS_YEAR_CURRENT, 32'h0000_2000);
    rd_chk(`RTCYD_OFS_YEAR_MATCH, 32'h0000_2000);
    rd_chk(`RTCYD_OFS_YEAR_LOAD, 32'h0000_0000);
    rd_chk(`RTCYD_OFS_DIV_TRIM_CTRL, 32'h0000_7FFF);
    rd_chk(`RTCYD_OFS_IRQ_MASK, 32'h0000_0000);
    rd_chk(`RTCYD_OFS_IRQ_RAW, 32'h0000_0000);
    wr(`RTCYD_OFS_YEAR_CURRENT, 32'h0000_1234);
    rd_chk(`RTCYD_OFS_YEAR_CURRENT, 32'h0000_2000);
    wr(`RTCYD_OFS_YEAR_MATCH, 32'hFFFF_3999);
    rd_chk(`RTCYD_OFS_YEAR_MATCH, 32'h0000_3999);
    apb_xfer(1'b0, 12'h030, 32'h0, rd, err);
    chk32({rd[31:1], err}, 32'h1);

    // Divider zero: timer gets every slow edge, calendar gets none
    wr(`RTCYD_OFS_DIV_TRIM_CTRL, 32'h0000_0000);
    count_ticks(20);
    chk_rng(tmr_n, 19, 21);
    chk_rng(cal_n, 0, 0);
    // Divider one, no trim: one tick per two slow edges over a full trim period
    wr(`RTCYD_OFS_DIV_TRIM_CTRL, 32'h0000_0001);
    count_ticks(1023);
    chk_rng(tmr_n, 510, 513);
    chk_rng(cal_n, 510, 513);
    // Ten slow edges dropped in any 1023 consecutive ones
    wr(`RTCYD_OFS_DIV_TRIM_CTRL, 32'h000A_0001);
    rd_chk(`RTCYD_OFS_DIV_TRIM_CTRL, 32'h000A_0001);
    count_ticks(1023);
    chk_rng(tmr_n, 505, 508);
    chk_rng(cal_n, 505, 508);

    // Interrupts: timer event, mask, masked view, clear and read-clear
    pulse(0);
    rd_chk(`RTCYD_OFS_IRQ_MASKED, 32'h0000_0000);
    chk32({31'h0, irq_o}, 32'h0);
    wr(`RTCYD_OFS_IRQ_MASK, 32'h0000_0002);
    repeat (2) @(posedge clock_i);
    chk32({31'h0, irq_o}, 32'h1);
    rd_chk(`RTCYD_OFS_IRQ_MASKED, 32'h0000_0002);
    wr(`RTCYD_OFS_IRQ_CLEAR, 32'h0000_0000);
    rd_chk(`RTCYD_OFS_IRQ_MASKED, 32'h0000_0002);
    wr(`RTCYD_OFS_IRQ_CLEAR, 32'h0000_0002);
    rd_chk(`RTCYD_OFS_IRQ_MASKED, 32'h0000_0000);
    chk32({31'h0, irq_o}, 32'h0);
    pulse(0);
    rd_chk(`RTCYD_OFS_IRQ_RAW, 32'h0000_0002);
    rd_chk(`RTCYD_OFS_IRQ_RAW, 32'h0000_0000);

    // Enable locks the control register until reset
    wr(`RTCYD_OFS_DIV_TRIM_CTRL, 32'h0400_0003);
    @(posedge clock_i);
    chk32({31'h0, calendar_enable_o}, 32'h1);
    wr(`RTCYD_OFS_DIV_TRIM_CTRL, 32'h0015_0005);
    rd_chk(`RTCYD_OFS_DIV_TRIM_CTRL, 32'h0400_0003);

    // Year load, match and rollover
    wr(`RTCYD_OFS_YEAR_LOAD, 32'h0000_2024);
    rd_chk(`RTCYD_OFS_YEAR_LOAD, 32'h0000_2024);
    rd_chk(`RTCYD_OFS_YEAR_CURRENT, 32'h0000_2024);
    wr(`RTCYD_OFS_YEAR_MATCH, 32'h0000_2024);
    wr(`RTCYD_OFS_IRQ_MASK, 32'h0000_0001);
    pulse(1);
    chk32({31'h0, irq_o}, 32'h1);
    rd_chk(`RTCYD_OFS_IRQ_MASKED, 32'h0000_0001);
    rd_chk(`RTCYD_OFS_IRQ_RAW, 32'h0000_0001);
    wr(`RTCYD_OFS_YEAR_MATCH, 32'h0000_2025);
    pulse(1);
    rd_chk(`RTCYD_OFS_IRQ_RAW, 32'h0000_0000);
    pulse(2);
    chk32({18'h0, year_value_o}, 32'h2025);
    pulse(1);
    wr(`RTCYD_OFS_IRQ_CLEAR, 32'h0000_0001);
    @(posedge clock_i);
    chk32({31'h0, irq_o}, 32'h0);
    wr(`RTCYD_OFS_YEAR_LOAD, 32'h0000_2099);
    pulse(2);
    rd_chk(`RTCYD_OFS_YEAR_CURRENT, 32'h0000_2100);
    wr(`RTCYD_OFS_YEAR_LOAD, 32'h0000_1999);
    pulse(2);
    rd_chk(`RTCYD_OFS_YEAR_CURRENT, 32'h0000_2000);

    // Only a reset lifts the lock
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rd_chk(`RTCYD_OFS_DIV_TRIM_CTRL, 32'h0000_7FFF);
    chk32({31'h0, calendar_enable_o}, 32'h0);
    rd_chk(`RTCYD_OFS_YEAR_MATCH, 32'h0000_2000);
    finish_test();
  end

  // Tests need under a millisecond; 2 ms keeps the run below the cycle budget
  initial begin
    #2ms;
    miscompares++;
    finish_test();
  end
endmodule
